// *** key_irq_top.sv ***
// key edge interrupt block, flag-retaining mode, with axi4-lite registers
// assumes synchronous key inputs, one 100 MHz clock, a synchronous high reset
//
// Behaviour
// (RULE_01) a valid edge on any of the six key inputs raises the key interrupt.
// (RULE_02) per-channel flags in the key flag register show which inputs saw a valid edge.
// (RULE_03) in flag mode the key interrupt stays high until the flags are cleared.
// (RULE_04) with falling edge chosen each falling edge gives exactly one interrupt, however the flag is cleared.
// (RULE_05) a flag clears on interrupt acknowledge or on a software write of one.
// (RULE_06) with the polarity setting at one, rising edges are the valid edge instead.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module key_irq_top
   import key_irq_pkg::*;
(
   input  wire logic                    SYS_CLK,
   input  wire logic                    SYS_RST,
   input  wire logic [KEY_CHANNELS-1:0] KEY_IN,
   input  wire logic                    KEY_IRQ_ACK,
   output logic                         KEY_IRQ,
   output logic                         IRQ,
   input  wire logic [ADDR_W-1:0]       S_AXI_AWADDR,
   input  wire logic                    S_AXI_AWVALID,
   output logic                         S_AXI_AWREADY,
   input  wire logic [31:0]             S_AXI_WDATA,
   input  wire logic [3:0]              S_AXI_WSTRB,
   input  wire logic                    S_AXI_WVALID,
   output logic                         S_AXI_WREADY,
   output logic [1:0]                   S_AXI_BRESP,
   output logic                         S_AXI_BVALID,
   input  wire logic                    S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0]       S_AXI_ARADDR,
   input  wire logic                    S_AXI_ARVALID,
   output logic                         S_AXI_ARREADY,
   output logic [31:0]                  S_AXI_RDATA,
   output logic [1:0]                   S_AXI_RRESP,
   output logic                         S_AXI_RVALID,
   input  wire logic                    S_AXI_RREADY
);
   // ****************************************
   // state
   // ****************************************
   logic                    flag_mode_select_q, flag_mode_select_d;
   logic                    edge_polarity_select_q, edge_polarity_select_d;
   logic [KEY_CHANNELS-1:0] chan_enable_q, chan_enable_d;
   logic [KEY_CHANNELS-1:0] key_flag_register_q, key_flag_register_d;
   logic [STAT_W-1:0]       status_q, status_d;
   logic [STAT_W-1:0]       mask_q, mask_d;
   logic                    key_irq_q, key_irq_d;
   logic                    irq_q, irq_d;
   logic                    aw_held_q, aw_held_d;
   logic [ADDR_W-1:0]       aw_addr_q, aw_addr_d;
   logic                    w_held_q, w_held_d;
   logic [31:0]             w_data_q, w_data_d;
   logic [3:0]              w_strb_q, w_strb_d;
   logic                    bvalid_q, bvalid_d;
   logic [1:0]              bresp_q, bresp_d;
   logic                    rvalid_q, rvalid_d;
   logic [31:0]             rdata_q, rdata_d;
   logic [1:0]              rresp_q, rresp_d;
   logic [KEY_CHANNELS-1:0] edge_pulse;
   logic [KEY_CHANNELS-1:0] valid_edge;
   logic                    do_write;
   logic                    do_read;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == ADDR_CTRL) || (a == ADDR_FLAG) || (a == ADDR_STATUS)
            || (a == ADDR_MASK) || (a == ADDR_INPUT);
   endfunction

   key_edge_detect u_edge (
      .clk        (SYS_CLK),
      .rst        (SYS_RST),
      .keys       (KEY_IN),
      .rising_sel (edge_polarity_select_q),
      .edge_pulse (edge_pulse)
   );

   // ****************************************
   // axi4-lite slave
   // ****************************************
   // one write and one read at a time; read ready held low while read data waits, write address and data still taken while a response waits
   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign do_read  = S_AXI_ARVALID && S_AXI_ARREADY;

   always_comb
   begin
      aw_held_d = aw_held_q;
      aw_addr_d = aw_addr_q;
      w_held_d  = w_held_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
         aw_held_d = 1'b1;
         aw_addr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
         w_held_d = 1'b1;
         w_data_d = S_AXI_WDATA;
         w_strb_d = S_AXI_WSTRB;
      end
      if (do_write)
      begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && S_AXI_BREADY)
         bvalid_d = 1'b0;
      if (do_read)
      begin
         rvalid_d = 1'b1;
         rresp_d  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
         rdata_d  = '0;
         case (S_AXI_ARADDR)
            ADDR_CTRL:
            begin
               rdata_d[CTRL_MODE_BIT] = flag_mode_select_q;
               rdata_d[CTRL_EDGE_BIT] = edge_polarity_select_q;
               rdata_d[CTRL_ENABLE_LO +: KEY_CHANNELS] = chan_enable_q;
            end
            ADDR_FLAG:   rdata_d[KEY_CHANNELS-1:0] = key_flag_register_q;   // [RULE_02]
            ADDR_STATUS: rdata_d[STAT_W-1:0] = status_q;
            ADDR_MASK:   rdata_d[STAT_W-1:0] = mask_q;
            ADDR_INPUT:  rdata_d[KEY_CHANNELS-1:0] = KEY_IN;
            default:     rdata_d = '0;
         endcase
      end
      else if (rvalid_q && S_AXI_RREADY)
         rvalid_d = 1'b0;
   end

   // ****************************************
   // key flags and interrupt
   // ****************************************
   assign valid_edge = edge_pulse & chan_enable_q;

   always_comb
   begin
      flag_mode_select_d     = flag_mode_select_q;
      edge_polarity_select_d = edge_polarity_select_q;
      chan_enable_d          = chan_enable_q;
      mask_d                 = mask_q;
      key_flag_register_d    = key_flag_register_q;
      status_d               = status_q;
      if (KEY_IRQ_ACK)
         key_flag_register_d = FLAGS_CLEAR;   // acknowledge clears the flags [RULE_05]
      if (do_write && w_strb_q[0])
      begin
         case (aw_addr_q)
            ADDR_CTRL:
            begin
               flag_mode_select_d     = w_data_q[CTRL_MODE_BIT];
               edge_polarity_select_d = w_data_q[CTRL_EDGE_BIT];
            end
            ADDR_FLAG:   key_flag_register_d = key_flag_register_d & ~w_data_q[KEY_CHANNELS-1:0];   // [RULE_05]
            ADDR_STATUS: status_d = status_q & ~w_data_q[STAT_W-1:0];
            ADDR_MASK:   mask_d = w_data_q[STAT_W-1:0];
            default:     mask_d = mask_q;
         endcase
      end
      if (do_write && w_strb_q[1] && aw_addr_q == ADDR_CTRL)
         chan_enable_d = w_data_q[CTRL_ENABLE_LO +: KEY_CHANNELS];
      // a new edge wins over a clear in the same cycle
      key_flag_register_d = key_flag_register_d | valid_edge;   // [RULE_02] [RULE_04]
      if (|valid_edge)
         status_d[STAT_KEY_BIT] = 1'b1;
      if (flag_mode_select_q)
         key_irq_d = |key_flag_register_q;   // held until flags cleared [RULE_03]
      else
         key_irq_d = |valid_edge;            // pulse mode: irq ignores the flags, which are still set
      key_irq_d = key_irq_d | (|valid_edge);   // [RULE_01]
      irq_d = |(status_d & mask_d);
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         flag_mode_select_q     <= 1'b0;
         edge_polarity_select_q <= 1'b0;
         chan_enable_q          <= ENABLE_RESET;
         key_flag_register_q    <= FLAGS_CLEAR;
         status_q               <= '0;
         mask_q                 <= '0;
         key_irq_q              <= 1'b0;
         irq_q                  <= 1'b0;
         aw_held_q              <= 1'b0;
         aw_addr_q              <= '0;
         w_held_q               <= 1'b0;
         w_data_q               <= '0;
         w_strb_q               <= '0;
         bvalid_q               <= 1'b0;
         bresp_q                <= RESP_OKAY;
         rvalid_q               <= 1'b0;
         rdata_q                <= '0;
         rresp_q                <= RESP_OKAY;
      end
      else
      begin
         flag_mode_select_q     <= flag_mode_select_d;
         edge_polarity_select_q <= edge_polarity_select_d;
         chan_enable_q          <= chan_enable_d;
         key_flag_register_q    <= key_flag_register_d;
         status_q               <= status_d;
         mask_q                 <= mask_d;
         key_irq_q              <= key_irq_d;
         irq_q                  <= irq_d;
         aw_held_q              <= aw_held_d;
         aw_addr_q              <= aw_addr_d;
         w_held_q               <= w_held_d;
         w_data_q               <= w_data_d;
         w_strb_q               <= w_strb_d;
         bvalid_q               <= bvalid_d;
         bresp_q                <= bresp_d;
         rvalid_q               <= rvalid_d;
         rdata_q                <= rdata_d;
         rresp_q                <= rresp_d;
      end
   end

   assign KEY_IRQ       = key_irq_q;
   assign IRQ           = irq_q;
   assign S_AXI_AWREADY = !aw_held_q && !SYS_RST;
   assign S_AXI_WREADY  = !w_held_q && !SYS_RST;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_ARREADY = !rvalid_q && !SYS_RST;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RDATA   = rdata_q;
   assign S_AXI_RRESP   = rresp_q;
endmodule // key_irq_top

// *** key_irq_pkg.sv ***
// key edge interrupt package: register map, field layout, reset values
// assumes a 32-bit axi4-lite register bus and six key inputs
package key_irq_pkg;
   localparam int          KEY_CHANNELS   = 6;
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_FLAG      = 8'h04;
   localparam logic [7:0]  ADDR_STATUS    = 8'h08;
   localparam logic [7:0]  ADDR_MASK      = 8'h0C;
   localparam logic [7:0]  ADDR_INPUT     = 8'h10;
   localparam int          CTRL_MODE_BIT  = 0;
   localparam int          CTRL_EDGE_BIT  = 1;
   localparam int          CTRL_ENABLE_LO = 8;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [5:0]  FLAGS_CLEAR    = 6'h00;
   localparam logic [5:0]  ENABLE_RESET   = 6'h3F;
   localparam logic [5:0]  INPUT_IDLE     = 6'h3F;
   localparam int          STAT_KEY_BIT   = 0;
   localparam int          STAT_W         = 1;
endpackage

// *** key_edge_detect.sv ***
// key edge detector: one-cycle pulse per valid edge on each channel
// assumes key inputs already synchronous to the system clock
`timescale 1ns/1ps
module key_edge_detect
   import key_irq_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [KEY_CHANNELS-1:0] keys,
   input  wire logic                    rising_sel,
   output logic      [KEY_CHANNELS-1:0] edge_pulse
);
   logic [KEY_CHANNELS-1:0] prev_q;
   logic [KEY_CHANNELS-1:0] prev_d;

   always_comb
   begin
      prev_d = keys;
      if (rising_sel)
      begin
         edge_pulse = keys & ~prev_q;   // [RULE_06]
      end
      else
      begin
         edge_pulse = ~keys & prev_q;   // only the falling edge counts [RULE_04]
      end
   end

   // idle high so a key released at reset gives no false edge; a key held low at reset gives a falling edge
   always_ff @(posedge clk)
   begin
      if (rst)
         prev_q <= INPUT_IDLE;
      else
         prev_q <= prev_d;
   end
endmodule // key_edge_detect

// *** key_irq_top_chk.sv ***
// checker: key interrupt and bus answer timing at the top ports
// assumes binding onto key_irq_top, one clock, reset high
`timescale 1ns/1ps
module key_irq_top_chk
   import key_irq_pkg::*;
(
   input wire logic                    SYS_CLK,
   input wire logic                    SYS_RST,
   input wire logic [KEY_CHANNELS-1:0] KEY_IN,
   input wire logic                    KEY_IRQ_ACK,
   input wire logic                    KEY_IRQ,
   input wire logic                    S_AXI_BVALID,
   input wire logic                    S_AXI_BREADY,
   input wire logic                    S_AXI_ARREADY,
   input wire logic                    S_AXI_RVALID,
   input wire logic                    S_AXI_RREADY
);
   // ********************
   // properties
   // ********************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // a fall and a rise at once: one is valid whatever the polarity, with every channel enabled
   chk_swap_raises: assert property (
      (|(~KEY_IN & $past(KEY_IN))) && (|(KEY_IN & ~$past(KEY_IN))) |=> KEY_IRQ)
      else $error("key irq missing after input edge");
   chk_rise_cause: assert property (
      $rose(KEY_IRQ) |-> $past(KEY_IN) != $past(KEY_IN, 2))
      else $error("key irq rose without an input edge");
   chk_ack_clears: assert property (
      (KEY_IRQ_ACK && $stable(KEY_IN)) ##1 $stable(KEY_IN) [*2] |-> !KEY_IRQ)
      else $error("key irq still high after acknowledge");
   chk_one_resp: assert property (
      S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response repeated");
   chk_read_block: assert property (
      S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read address taken while data pending");
   chk_one_read: assert property (
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read data repeated");
endmodule // key_irq_top_chk

bind key_irq_top key_irq_top_chk u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .KEY_IN(KEY_IN),
   .KEY_IRQ_ACK(KEY_IRQ_ACK), .KEY_IRQ(KEY_IRQ), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY));

// *** key_switch_model.sv ***
// key switch model: a pressed key pulls its line low
// assumes a pull-up on every line and bounce-free contacts
`timescale 1ns/1ps
module key_switch_model
   import key_irq_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic [KEY_CHANNELS-1:0] press,
   output logic      [KEY_CHANNELS-1:0] keys
);
   // lines change just after an edge, so inputs look synchronous
   always_ff @(posedge clk)
   begin
      keys <= ~press;
   end
endmodule // key_switch_model

// *** key_edge_interrupt_flag_mode_tb_top.sv ***
// testbench: key interrupt block driven over its register bus
// assumes the switch model on the key lines and the bound checker
`timescale 1ns/1ps
module key_edge_interrupt_flag_mode_tb_top
   import key_irq_pkg::*;
();
   logic                    clk = 1'b0, rst = 1'b1, ack = 1'b0;
   logic                    awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [KEY_CHANNELS-1:0] press = '0, keys;
   logic [ADDR_W-1:0]       awa = '0, ara = '0;
   logic [31:0]             wd = '0, rdat;
   logic [1:0]              bresp, rresp;
   logic                    kirq, irq, awr, wrdy, bv, arr, rv;
   int                      fails = 0, compares = 0, cyc = 0;

   key_switch_model SW (.clk(clk), .press(press), .keys(keys));
   key_irq_top DUT (.SYS_CLK(clk), .SYS_RST(rst), .KEY_IN(keys), .KEY_IRQ_ACK(ack), .KEY_IRQ(kirq),
      .IRQ(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rr));

   // ********************
   // tasks
   // ********************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      br  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end
      while (!bv);
      br <= 1'b0;
      check(32'(bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end
      while (!rv);
      rr <= 1'b0;
      check(rdat, e);
      check(32'(rresp), 32'(er));
   endtask

   // keys reach the block one edge later; irq follows one edge after that
   task automatic key(input logic [KEY_CHANNELS-1:0] p);
      @(posedge clk);
      press <= p;
      repeat (4) @(posedge clk);
   endtask

   task automatic pins(input logic k, input logic i);
      repeat (3) @(posedge clk);
      check(32'(kirq), 32'(k));
      check(32'(irq), 32'(i));
   endtask

   // ********************
   // sequence
   // ********************
   initial
   begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fails++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_CTRL, {18'h0, ENABLE_RESET, 8'h00}, RESP_OKAY);
      rd(ADDR_FLAG, 32'h0, RESP_OKAY);
      rd(8'h14, 32'h0, RESP_SLVERR);
      wr(8'h14, 32'h1, RESP_SLVERR);
      wr(ADDR_CTRL, 32'h3F01, RESP_OKAY);
      wr(ADDR_MASK, 32'h1, RESP_OKAY);
      key(6'h01);
      pins(1'b1, 1'b1);
      wr(ADDR_MASK, 32'h0, RESP_OKAY);
      pins(1'b1, 1'b0);
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      wr(ADDR_MASK, 32'h1, RESP_OKAY);
      key(6'h00);
      pins(1'b1, 1'b0);
      rd(ADDR_FLAG, 32'h01, RESP_OKAY);
      wr(ADDR_FLAG, 32'h01, RESP_OKAY);
      pins(1'b0, 1'b0);
      key(6'h20);
      wr(ADDR_FLAG, 32'h20, RESP_OKAY);
      key(6'h00);
      pins(1'b0, 1'b1);
      rd(ADDR_FLAG, 32'h0, RESP_OKAY);
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      key(6'h0C);
      rd(ADDR_FLAG, 32'h0C, RESP_OKAY);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      pins(1'b0, 1'b1);
      rd(ADDR_FLAG, 32'h0, RESP_OKAY);
      key(6'h00);
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      pins(1'b0, 1'b0);
      wr(ADDR_CTRL, 32'h3F03, RESP_OKAY);
      key(6'h10);
      pins(1'b0, 1'b0);
      key(6'h01);
      pins(1'b1, 1'b1);
      rd(ADDR_FLAG, 32'h10, RESP_OKAY);
      rd(ADDR_INPUT, 32'h3E, RESP_OKAY);
      // pulse mode: one-cycle request per falling edge
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      wr(ADDR_CTRL, 32'h3F00, RESP_OKAY);
      @(posedge clk);
      press <= 6'h03;
      repeat (3) @(posedge clk);
      check(32'(kirq), 32'h1);
      @(posedge clk);
      check(32'(kirq), 32'h0);
      // disabled channel: its edge is not a valid edge
      wr(ADDR_FLAG, 32'h3F, RESP_OKAY);
      wr(ADDR_STATUS, 32'h1, RESP_OKAY);
      wr(ADDR_CTRL, 32'h3B01, RESP_OKAY);
      key(6'h07);
      pins(1'b0, 1'b0);
      rd(ADDR_FLAG, 32'h0, RESP_OKAY);
      rd(ADDR_CTRL, 32'h3B01, RESP_OKAY);
      give_verdict();
   end
endmodule // key_edge_interrupt_flag_mode_tb_top
